// ### design/sdc_filter_path.sv
// Codec filter path: sinc3 decimator, sinc3 interpolator, modulator, AXI4-Lite registers
`timescale 1ns/1ps
module sdc_filter_path #(
  parameter int BIT_DIV = sdc_pkg::SDC_BIT_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic enc_mod_bit,
  output logic enc_bit_strobe,
  output logic [sdc_pkg::SDC_SAMPLE_W-1:0] serial_sample_output,
  output logic enc_sample_valid,
  output logic dac_bit,
  output logic dac_bit_valid,
  output logic out_mute,
  output logic [2:0] out_gain_sel,
  output logic ref_buffer_enable
);
  import sdc_pkg::*;

  localparam int DW = SDC_ACC_W;
  localparam int IW = SDC_SAMPLE_W + 2 * SDC_MAX_LOG2N + 1;

  // Control registers
  logic [7:0] filter_control_reg_q;
  logic [7:0] gain_control_reg_q;
  logic [7:0] ref_ctrl_q;
  logic [15:0] dec_in_q;
  logic dec_new_q;
  logic [7:0] dec_miss_q;
  sdc_rate_e rate;
  sdc_rate_e rate_q;
  logic mixed_mode;
  logic interp_bypass;
  assign rate = sdc_rate_e'(filter_control_reg_q[SDC_RATE_LSB +: 2]);
  assign mixed_mode = filter_control_reg_q[SDC_MIXED_BIT];
  assign interp_bypass = filter_control_reg_q[SDC_BYPASS_BIT];

  // Bit-rate and sample-period timing
  logic [7:0] div_q;
  logic bit_tick;
  logic [7:0] phase_q;
  logic [7:0] last_phase;
  logic frame_tick;
  logic [3:0] log2n;
  always_comb begin
    unique case (rate)
      SDC_RATE_64K: log2n = 4'h5;
      SDC_RATE_32K: log2n = 4'h6;
      SDC_RATE_16K: log2n = 4'h7;
      SDC_RATE_8K: log2n = 4'h8;
    endcase
  end
  assign last_phase = 8'((9'h001 << log2n) - 9'h001);
  assign bit_tick = (div_q == 8'(BIT_DIV - 1));
  assign frame_tick = bit_tick && (phase_q >= last_phase);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 8'h00;
      rate_q <= SDC_RATE_64K;
    end else begin
      div_q <= bit_tick ? 8'h00 : div_q + 8'h01;
      rate_q <= rate;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= 8'h00;
    end else if (bit_tick) begin
      phase_q <= frame_tick ? 8'h00 : phase_q + 8'h01;
    end
  end

  // Decimator: three integrators at bit rate, three combs at sample rate
  logic signed [DW-1:0] integ_q [3];
  logic signed [DW-1:0] comb_dly_q [3];
  logic signed [DW-1:0] comb_in [4];
  logic signed [DW-1:0] mod_in;
  assign mod_in = enc_mod_bit ? DW'(1) : -DW'(1);
  assign comb_in[0] = integ_q[2];

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_stage
      logic signed [DW-1:0] integ_src;
      assign integ_src = (g == 0) ? mod_in : integ_q[(g == 0) ? 0 : g - 1];
      assign comb_in[g+1] = comb_in[g] - comb_dly_q[g];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          integ_q[g] <= '0;
        end else if (bit_tick) begin
          integ_q[g] <= integ_q[g] + integ_src;
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          comb_dly_q[g] <= '0;
        end else if (frame_tick) begin
          comb_dly_q[g] <= comb_in[g];
        end
      end
    end
  endgenerate

  // Scale the 3*log2n bit result to 18 bits, then format
  logic signed [DW-1:0] dec_full;
  logic signed [SDC_ENC_W-1:0] dec18;
  logic [15:0] enc_word;
  assign dec_full = comb_in[3];
  always_comb begin
    // Growth of 3*log2n bits plus sign; keep top 18
    dec18 = SDC_ENC_W'(dec_full >>> (5'(3) * 5'(log2n) + 5'd1 - 5'(SDC_ENC_W)));
    if (log2n == 4'h5) begin
      dec18 = SDC_ENC_W'(dec_full <<< 2);
    end
    enc_word = dec18[SDC_ENC_W-1 -: 16];
    if (mixed_mode) begin
      enc_word = {1'b0, dec18[SDC_ENC_W-1 -: 15]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_sample_output <= '0;
      enc_sample_valid <= 1'b0;
    end else begin
      enc_sample_valid <= frame_tick;
      if (frame_tick) begin
        serial_sample_output <= enc_word;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enc_bit_strobe <= 1'b0;
    end else begin
      enc_bit_strobe <= bit_tick;
    end
  end

  // Interpolator: combs at sample rate, integrators at bit rate
  logic signed [IW-1:0] icomb_dly_q [3];
  logic signed [IW-1:0] icomb [4];
  logic signed [IW-1:0] iint_q [3];
  assign icomb[0] = IW'($signed(dec_in_q));
  generate
    for (g = 0; g < 3; g++) begin : g_istage
      assign icomb[g+1] = icomb[g] - icomb_dly_q[g];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          icomb_dly_q[g] <= '0;
        end else if (rate != rate_q) begin
          icomb_dly_q[g] <= '0; // Uneven frame spacing would leave the integrators drifting
        end else if (frame_tick) begin
          icomb_dly_q[g] <= icomb[g];
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          iint_q[g] <= '0;
        end else if (rate != rate_q) begin
          iint_q[g] <= '0;
        end else if (bit_tick) begin
          iint_q[g] <= iint_q[g] + ((g == 0) ? (frame_tick ? icomb[3] : '0) : iint_q[(g == 0) ? 0 : g - 1]);
        end
      end
    end
  endgenerate

  // Interpolated value normalised back to 16 bits (gain N^3 / N zero-stuff = N^2)
  logic signed [15:0] interp16;
  logic signed [15:0] mod_src;
  assign interp16 = 16'(iint_q[2] >>> (5'(2) * 5'(log2n)));
  assign mod_src = interp_bypass ? $signed(dec_in_q) : interp16;

  // First-order digital sigma-delta modulator
  logic signed [17:0] sd_acc_q;
  logic signed [17:0] fb;
  assign fb = sd_acc_q[17] ? -18'sh08000 : 18'sh07FFF;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sd_acc_q <= '0;
      dac_bit <= 1'b0;
      dac_bit_valid <= 1'b0;
    end else begin
      dac_bit_valid <= bit_tick;
      if (bit_tick) begin
        sd_acc_q <= sd_acc_q + 18'(mod_src) - fb;
        dac_bit <= ~sd_acc_q[17] & ~gain_control_reg_q[SDC_MUTE_BIT];
      end
    end
  end

  // Outputs for analog controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_mute <= 1'b0;
      out_gain_sel <= 3'h0;
      ref_buffer_enable <= 1'b0;
    end else begin
      out_mute <= gain_control_reg_q[SDC_MUTE_BIT];
      out_gain_sel <= gain_control_reg_q[SDC_GAIN_LSB +: 3];
      ref_buffer_enable <= ref_ctrl_q[SDC_REFEN_BIT];
    end
  end

  // AXI4-Lite slave
  logic [7:0] wa;
  logic wr_do;
  logic wr_hit;
  assign wa = s_axi_awaddr[7:0];
  assign wr_do = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign wr_hit = (wa == SDC_OFF_FILTER_CTRL) || (wa == SDC_OFF_GAIN_CTRL) ||
                  (wa == SDC_OFF_REF_CTRL) || (wa == SDC_OFF_DEC_SAMPLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SDC_RESP_OKAY;
    end else begin
      s_axi_awready <= wr_do && !s_axi_awready;
      s_axi_wready <= wr_do && !s_axi_awready;
      if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? SDC_RESP_OKAY : SDC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filter_control_reg_q <= SDC_FILTER_CTRL_RST;
      gain_control_reg_q <= SDC_GAIN_CTRL_RST;
      ref_ctrl_q <= SDC_REF_CTRL_RST;
    end else if (s_axi_awready && s_axi_wstrb[0]) begin
      if (wa == SDC_OFF_FILTER_CTRL) filter_control_reg_q <= s_axi_wdata[7:0];
      if (wa == SDC_OFF_GAIN_CTRL) gain_control_reg_q <= s_axi_wdata[7:0];
      if (wa == SDC_OFF_REF_CTRL) ref_ctrl_q <= s_axi_wdata[7:0];
    end
  end

  // Decoder sample holding: a new word is used at the next period, else the old one
  logic dec_wr;
  assign dec_wr = s_axi_awready && (wa == SDC_OFF_DEC_SAMPLE) && (s_axi_wstrb[1:0] == 2'b11);
  logic [15:0] dec_pend_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dec_pend_q <= 16'h0000;
      dec_in_q <= 16'h0000;
      dec_new_q <= 1'b0;
      dec_miss_q <= 8'h00;
    end else begin
      if (dec_wr) begin
        dec_pend_q <= s_axi_wdata[15:0];
      end
      if (frame_tick) begin
        if (dec_new_q || dec_wr) begin
          dec_in_q <= dec_wr ? s_axi_wdata[15:0] : dec_pend_q;
        end else begin
          dec_miss_q <= dec_miss_q + 8'h01;
        end
        dec_new_q <= 1'b0;
      end else if (dec_wr) begin
        dec_new_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SDC_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= SDC_RESP_OKAY;
        unique case (s_axi_araddr[7:0])
          SDC_OFF_FILTER_CTRL: s_axi_rdata <= {24'h000000, filter_control_reg_q};
          SDC_OFF_GAIN_CTRL: s_axi_rdata <= {24'h000000, gain_control_reg_q};
          SDC_OFF_REF_CTRL: s_axi_rdata <= {24'h000000, ref_ctrl_q};
          SDC_OFF_DEC_SAMPLE: s_axi_rdata <= {16'h0000, dec_in_q};
          SDC_OFF_ENC_SAMPLE: s_axi_rdata <= {16'h0000, serial_sample_output};
          SDC_OFF_STATUS: s_axi_rdata <= {16'h0000, dec_miss_q, 7'h00, dec_new_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SDC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ### design/sdc_pkg.sv
// Package for the sigma-delta codec filter path
package sdc_pkg;
  // Register byte offsets
  localparam logic [7:0] SDC_OFF_FILTER_CTRL = 8'h00;
  localparam logic [7:0] SDC_OFF_GAIN_CTRL = 8'h04;
  localparam logic [7:0] SDC_OFF_REF_CTRL = 8'h08;
  localparam logic [7:0] SDC_OFF_DEC_SAMPLE = 8'h0C;
  localparam logic [7:0] SDC_OFF_ENC_SAMPLE = 8'h10;
  localparam logic [7:0] SDC_OFF_STATUS = 8'h14;
  // Field positions
  localparam int SDC_RATE_LSB = 0;
  localparam int SDC_MIXED_BIT = 3;
  localparam int SDC_BYPASS_BIT = 5;
  localparam int SDC_GAIN_LSB = 4;
  localparam int SDC_MUTE_BIT = 7;
  localparam int SDC_REFEN_BIT = 6;
  // Reset values
  localparam logic [7:0] SDC_FILTER_CTRL_RST = 8'h00;
  localparam logic [7:0] SDC_GAIN_CTRL_RST = 8'h00;
  localparam logic [7:0] SDC_REF_CTRL_RST = 8'h00;
  // Rate and width figures
  localparam int SDC_BIT_DIV = 8;
  localparam int SDC_MIN_LOG2N = 5;
  localparam int SDC_MAX_LOG2N = 8;
  localparam int SDC_ACC_W = 3 * SDC_MAX_LOG2N + 1;
  localparam int SDC_ENC_W = 18;
  localparam int SDC_SAMPLE_W = 16;
  localparam real SDC_CLK_MHZ = 25.0;
  localparam real SDC_MIN_GD_US = 25.0;
  localparam int SDC_MIN_GD_CYC = $rtoi(SDC_MIN_GD_US * SDC_CLK_MHZ);
  localparam logic [1:0] SDC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SDC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SDC_RATE_64K = 2'b00,
    SDC_RATE_32K = 2'b01,
    SDC_RATE_16K = 2'b10,
    SDC_RATE_8K = 2'b11
  } sdc_rate_e;

  typedef struct packed {
    logic mute;
    logic [2:0] gain_sel;
    logic ref_en;
    logic bypass;
  } sdc_ctrl_s;
endpackage

// ### sim/sdc_filter_path_assertions.sv
// Bus and stream timing checks for the codec filter path
`timescale 1ns/1ps
module sdc_filter_path_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic enc_bit_strobe,
  input wire logic [15:0] serial_sample_output,
  input wire logic enc_sample_valid,
  input wire logic dac_bit,
  input wire logic dac_bit_valid,
  input wire logic out_mute
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take; s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid; endsequence
  sequence wr_done; s_axi_awready && s_axi_wready ##1 s_axi_bvalid; endsequence
  sequence rd_take; s_axi_arvalid && !s_axi_arready && !s_axi_rvalid; endsequence
  sequence rd_done; s_axi_arready ##1 s_axi_rvalid; endsequence
  write_answer_a: assert property (wr_take |=> wr_done)
    else $error("write answer out of time");
  read_answer_a: assert property (rd_take |=> rd_done)
    else $error("read answer out of time");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  bit_rate_a: assert property (enc_bit_strobe |=> !enc_bit_strobe [*7] ##1 enc_bit_strobe)
    else $error("bit strobe spacing wrong");
  dac_rate_a: assert property (dac_bit_valid |=> !dac_bit_valid [*7] ##1 dac_bit_valid)
    else $error("output bit spacing wrong");
  mute_silence_a: assert property (out_mute && $past(out_mute) && dac_bit_valid |-> !dac_bit)
    else $error("muted output not silent");
  word_hold_a: assert property (!enc_sample_valid |-> $stable(serial_sample_output))
    else $error("sample word changed without valid");
endmodule

bind sdc_filter_path sdc_filter_path_assertions i_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .enc_bit_strobe(enc_bit_strobe), .serial_sample_output(serial_sample_output),
  .enc_sample_valid(enc_sample_valid), .dac_bit(dac_bit), .dac_bit_valid(dac_bit_valid), .out_mute(out_mute));

// ### sim/sdc_filter_path_tb.sv
// Self-checking bench for the codec filter path
`timescale 1ns/1ps
module sdc_filter_path_tb;
  import sdc_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 0, pattern = 4'h7;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, enc_mod_bit;
  logic enc_bit_strobe, enc_sample_valid, dac_bit, dac_bit_valid, out_mute, ref_buffer_enable;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] serial_sample_output;
  logic [2:0] out_gain_sel;
  int mismatches = 0;
  int checks_done = 0;
  initial forever #20 aclk = ~aclk;
  sdc_filter_path i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .enc_mod_bit(enc_mod_bit), .enc_bit_strobe(enc_bit_strobe),
    .serial_sample_output(serial_sample_output), .enc_sample_valid(enc_sample_valid), .dac_bit(dac_bit),
    .dac_bit_valid(dac_bit_valid), .out_mute(out_mute), .out_gain_sel(out_gain_sel),
    .ref_buffer_enable(ref_buffer_enable));
  sdc_mod_model i_mod (.aclk(aclk), .aresetn(aresetn), .enc_bit_strobe(enc_bit_strobe),
    .pattern(pattern), .enc_mod_bit(enc_mod_bit));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask
  task automatic rdr(input logic [7:0] a, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    check(s_axi_rresp, er);
  endtask
  task automatic wait_word(output int gap);
    gap = 0;
    do begin
      @(posedge aclk);
      gap++;
    end while (!enc_sample_valid);
  endtask
  task automatic dac_ones(output int ones);
    ones = 0;
    repeat (64) begin
      do @(posedge aclk); while (!dac_bit_valid);
      ones += int'(dac_bit);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    wrap_up();
  end
  initial begin
    int g;
    logic [7:0] offs[3];
    offs = '{SDC_OFF_FILTER_CTRL, SDC_OFF_GAIN_CTRL, SDC_OFF_REF_CTRL};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (offs[i]) begin
      rdr(offs[i], SDC_RESP_OKAY);
      check(rd, 0);
    end
    for (int k = 0; k < 8; k++) begin
      wr(SDC_OFF_GAIN_CTRL, 32'(k << 4) | 32'h80, SDC_RESP_OKAY);
      rdr(SDC_OFF_GAIN_CTRL, SDC_RESP_OKAY);
      check(rd, 32'(k << 4) | 32'h80);
      check(out_gain_sel, 32'(k));
      check(out_mute, 1);
    end
    for (int j = 1; j >= 0; j--) begin
      wr(SDC_OFF_REF_CTRL, 32'(j << 6), SDC_RESP_OKAY);
      repeat (2) @(posedge aclk);
      check(ref_buffer_enable, 32'(j));
    end
    wr(8'h40, 0, SDC_RESP_SLVERR);
    rdr(8'h40, SDC_RESP_SLVERR);
    check(rd, 0);
    $display("register test done");
    repeat (5) wait_word(g);
    check(g, 8 * 32);
    check(serial_sample_output[1:0], 0);
    check(serial_sample_output[15], 0);
    check(serial_sample_output, 16'h4000);
    pattern <= 4'h1;
    g = 0;
    do begin
      @(posedge aclk);
      g++;
    end while (!serial_sample_output[15] && g < 4000);
    check(g <= SDC_MIN_GD_CYC, 1);
    repeat (3) wait_word(g);
    check(serial_sample_output[15], 1);
    check(serial_sample_output[1:0], 0);
    check(serial_sample_output, 16'hC000);
    wr(SDC_OFF_FILTER_CTRL, 32'h8, SDC_RESP_OKAY);
    repeat (2) wait_word(g);
    check(serial_sample_output[15], 0);
    check(serial_sample_output, 16'h6000);
    wr(SDC_OFF_FILTER_CTRL, 32'h3, SDC_RESP_OKAY);
    repeat (4) wait_word(g);
    check(g, 8 * 256);
    check(serial_sample_output, 16'hC000);
    $display("encoder test done");
    wr(SDC_OFF_FILTER_CTRL, 32'h20, SDC_RESP_OKAY);
    rdr(SDC_OFF_FILTER_CTRL, SDC_RESP_OKAY);
    check(rd, 32'h20);
    wr(SDC_OFF_GAIN_CTRL, 0, SDC_RESP_OKAY);
    wr(SDC_OFF_DEC_SAMPLE, 32'h7FFF, SDC_RESP_OKAY);
    repeat (600) @(posedge aclk);
    dac_ones(g);
    check(g >= 60, 1);
    wr(SDC_OFF_DEC_SAMPLE, 32'h8000, SDC_RESP_OKAY);
    repeat (600) @(posedge aclk);
    rdr(SDC_OFF_DEC_SAMPLE, SDC_RESP_OKAY);
    check(rd, 32'h8000);
    dac_ones(g);
    check(g <= 4, 1);
    rdr(SDC_OFF_STATUS, SDC_RESP_OKAY);
    check(rd[15:8] != 0, 1);
    wr(SDC_OFF_DEC_SAMPLE, 32'h7FFF, SDC_RESP_OKAY);
    repeat (600) @(posedge aclk);
    dac_ones(g);
    check(g >= 60, 1);
    wr(SDC_OFF_GAIN_CTRL, 32'h80, SDC_RESP_OKAY);
    dac_ones(g);
    check(g, 0);
    wr(SDC_OFF_GAIN_CTRL, 0, SDC_RESP_OKAY);
    wr(SDC_OFF_FILTER_CTRL, 0, SDC_RESP_OKAY);
    wr(SDC_OFF_DEC_SAMPLE, 32'h8000, SDC_RESP_OKAY);
    repeat (1200) @(posedge aclk);
    dac_ones(g);
    check(g <= 4, 1);
    $display("decoder test done");
    wrap_up();
  end
endmodule

// ### sim/sdc_mod_model.sv
// Encoder modulator bit source model
`timescale 1ns/1ps
module sdc_mod_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enc_bit_strobe,
  input wire logic [3:0] pattern,
  output logic enc_mod_bit
);
  logic [1:0] idx_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) idx_q <= 2'h0;
    else if (enc_bit_strobe) idx_q <= idx_q + 2'h1;
  end
  assign enc_mod_bit = pattern[idx_q];
endmodule
